// >>> logic/apc_pkg.sv
// Constants, types and helpers for the port command block.
// Assumes a 32-bit AHB-Lite register bus and one 10 MHz clock.
package apc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] APC_OFS_CAP    = 32'h0000_00a4;
    localparam logic [31:0] APC_OFS_CMD    = 32'h0000_00a8;
    localparam logic [31:0] APC_OFS_STATUS = 32'h0000_00c0;

    // Capability word: rates 111, fast write, sideband, 32 requests
    localparam logic [31:0] APC_CAP_VALUE  = 32'h1f00_0217;
    localparam logic [31:0] APC_CMD_RESET  = 32'h0000_0000;
    // Writable bits 9, 8, 4 and 2:0; all others read zero
    localparam logic [31:0] APC_CMD_WMASK  = 32'h0000_0317;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int APC_SB_EN_BIT   = 9;
    localparam int APC_PORT_EN_BIT = 8;
    localparam int APC_FW_EN_BIT   = 4;
    localparam int APC_RATE_LSB    = 0;
    localparam int APC_RATE_W      = 3;

    // Status bits
    localparam int APC_ST_PEND_BIT = 0;
    localparam int APC_ST_SRC_BIT  = 1;
    localparam int APC_ST_FAST_BIT = 2;
    localparam int APC_ST_SYNC_BIT = 3;
    localparam int APC_ST_RATE_LSB = 4;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    localparam logic [2:0] APC_RATE_1X  = 3'h1;
    localparam logic [2:0] APC_RATE_2X  = 3'h2;
    localparam logic [2:0] APC_RATE_4X  = 3'h4;
    localparam logic [7:0] APC_SB_IDLE  = 8'hff;
    localparam logic [2:0] APC_HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic       port_enable;
        logic       sideband_address_enable;
        logic       fast_write_enable;
        logic [2:0] rate_select;
    } apc_ctrl_type;

    typedef struct packed {
        logic        from_sideband;
        logic [15:0] cmd;
    } apc_op_type;

    // One-hot rate decode; anything not one-hot falls back to 1x
    function automatic logic [2:0] apc_rate_decode(input logic [2:0] sel);
        logic [2:0] r;
        unique case (sel)
            APC_RATE_2X: r = APC_RATE_2X;
            APC_RATE_4X: r = APC_RATE_4X;
            default:     r = APC_RATE_1X;
        endcase
        return r;
    endfunction : apc_rate_decode

endpackage : apc_pkg

// >>> logic/apc_sync.sv
// Two flip-flop synchroniser for pins arriving from the port.
// Assumes inputs are quasi-static relative to clk_i.
`timescale 1ns/10ps
module apc_sync
    import apc_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    // ------------------------------------------------------------
    // Sync stages; first stage feeds only the second
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= RESET_VAL;
            q_o    <= RESET_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : apc_sync

// >>> logic/apc_sideband.sv
// Sideband request assembler: two 1x bytes form one 16-bit request.
// Assumes a synchronised byte stream where all-ones means idle.
`timescale 1ns/10ps
module apc_sideband
    import apc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic [7:0]  byte_i,
    input  wire logic        accept_i,
    input  wire logic        ready_i,
    output logic             valid_o,
    output logic [15:0]      cmd_o
);
    typedef enum logic [1:0] {SB_IDLE, SB_SECOND, SB_HOLD} apc_sb_state_type;

    apc_sb_state_type state_q;
    logic [7:0]       high_q;

    assign valid_o = (state_q == SB_HOLD);

    // ------------------------------------------------------------
    // Byte pairing
    // ------------------------------------------------------------
    // Enable is checked on the first byte only, so a request already
    // under way still completes if the port is disabled mid-way.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= SB_IDLE;
            high_q  <= 8'h00;
            cmd_o   <= 16'h0000;
        end else begin
            unique case (state_q)
                SB_IDLE: begin
                    if (accept_i && byte_i != APC_SB_IDLE) begin
                        high_q  <= byte_i;
                        state_q <= SB_SECOND;
                    end
                end
                SB_SECOND: begin
                    cmd_o   <= {high_q, byte_i};
                    state_q <= SB_HOLD;
                end
                SB_HOLD: begin
                    if (ready_i) begin
                        state_q <= SB_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : apc_sideband

// >>> logic/apc_top.sv
// Port command register, AHB-Lite slave and the control it steers.
// Assumes one 10 MHz clock; port pins are asynchronous to it and
// the transaction engines sit on the same clock.
//
// What this block does
// - Sideband enable set: requests over the sideband bus are accepted.
// - Port enable clear: every port operation and sync cycle ignored.
// - Operation accepted while enabled completes even if enable clears.
// - Sideband request mid-delivery in 1x still issues when enable drops.
// - Enabled port serves pipe requests; sideband only with its enable too.
// - Fast write enable set: host memory writes use fast write protocol.
// - Fast writes run at the rate held in the rate select field.
// - Fast write off or 1x rate: host memory writes use plain PCI.
// - Rate select one-hot: 001 is 1x, 010 is 2x, 100 is 4x.
// - Chosen rate drives address/data bus, sideband bus and fast writes.
// - Capability field reports 1x, 2x and 4x support, reading 111.
//
// Register access over AHB-Lite is this design's own decision.

`timescale 1ns/10ps
module apc_top
    import apc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,

    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,

    // Port pins from the graphics master
    input  wire logic        pipe_req_n_i,
    input  wire logic [15:0] pipe_cmd_i,
    input  wire logic [7:0]  sb_addr_i,
    input  wire logic        sb_sync_i,

    // Toward the transaction engines
    output logic             op_valid_o,
    output apc_op_type       op_o,
    input  wire logic        op_done_i,
    output logic             sync_done_o,
    output logic      [2:0]  xfer_rate_o,
    input  wire logic        wr_req_i,
    output logic             wr_fast_o,
    output logic      [2:0]  wr_rate_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Register side
    apc_ctrl_type ctrl_q;
    apc_ctrl_type ctrl_d;

    logic [31:0]  cmd_word;
    logic [31:0]  status_word;
    logic [31:0]  rd_mux;

    // Bus phases
    logic         addr_ph;
    logic         wr_pend_q;
    logic [31:0]  wr_addr_q;

    logic         cmd_wr;

    // Pins after sync
    logic         pipe_req_n_s;
    logic [15:0]  pipe_cmd_s;
    logic [7:0]   sb_addr_s;
    logic         sync_s;

    // Sync edge state
    logic         sync_prev_q;
    logic         sync_rise;

    logic         sync_seen_q;

    // Issue path
    logic         pending_q;
    apc_op_type   op_q;

    logic         sb_accept;
    logic         sb_valid;
    logic [15:0]  sb_cmd;

    logic         sb_take;
    logic         pipe_take;

    // Rate use
    logic [2:0]   eff_rate;
    logic         fast_sel;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Request strobe idles high, sideband bus idles all-ones
    apc_sync #(
        .WIDTH     (1),
        .RESET_VAL (1'b1)
    ) u_sync_pipe (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .d_i       (pipe_req_n_i),
        .q_o       (pipe_req_n_s)
    );

    // Word shares strobe latency
    apc_sync #(
        .WIDTH     (16),
        .RESET_VAL (16'h0000)
    ) u_sync_pcmd (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .d_i       (pipe_cmd_i),
        .q_o       (pipe_cmd_s)
    );

    // Bytes idle all-ones
    apc_sync #(
        .WIDTH     (8),
        .RESET_VAL (APC_SB_IDLE)
    ) u_sync_sb (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .d_i       (sb_addr_i),
        .q_o       (sb_addr_s)
    );

    // Sync idles low
    apc_sync #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_sync_sync (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .d_i       (sb_sync_i),
        .q_o       (sync_s)
    );

    // ------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    // Only full-word transfers write; other sizes are ignored
    assign addr_ph     = hsel_i && hready_i && htrans_i[1];
    assign cmd_wr      = wr_pend_q && (wr_addr_q == APC_OFS_CMD);

    // No stalls, no errors
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // Address phase capture for the following data phase
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= addr_ph && hwrite_i && (hsize_i == APC_HSIZE_WORD);
            wr_addr_q <= haddr_i;
        end
    end

    // ------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------
    // Only the writable fields are stored; reserved bits cannot stick
    always_comb begin
        ctrl_d = ctrl_q;

        if (cmd_wr) begin
            ctrl_d.port_enable             = hwdata_i[APC_PORT_EN_BIT];
            ctrl_d.sideband_address_enable = hwdata_i[APC_SB_EN_BIT];
            ctrl_d.fast_write_enable       = hwdata_i[APC_FW_EN_BIT];
            ctrl_d.rate_select =
                hwdata_i[APC_RATE_LSB +: APC_RATE_W];
        end
    end

    // Register state, cleared at reset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_q <= apc_ctrl_type'(6'h00);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Read image of a control set, reserved bits zero
    function automatic logic [31:0] cmd_image(input apc_ctrl_type c);
        logic [31:0] w;
        w = APC_CMD_RESET;

        w[APC_PORT_EN_BIT]                = c.port_enable;
        w[APC_SB_EN_BIT]                  = c.sideband_address_enable;
        w[APC_FW_EN_BIT]                  = c.fast_write_enable;
        w[APC_RATE_LSB +: APC_RATE_W]     = c.rate_select;
        return w & APC_CMD_WMASK;
    endfunction : cmd_image

    // Reads see a write from the previous data phase at once
    assign cmd_word = cmd_image(ctrl_d);

    // ------------------------------------------------------------
    // Status word of the block's own state
    // ------------------------------------------------------------
    // Live state for software
    always_comb begin
        status_word                      = 32'h0000_0000;

        status_word[APC_ST_PEND_BIT]     = pending_q;
        status_word[APC_ST_SRC_BIT]      = op_q.from_sideband;
        status_word[APC_ST_FAST_BIT]     = fast_sel;
        status_word[APC_ST_SYNC_BIT]     = sync_seen_q;
        status_word[APC_ST_RATE_LSB +: 3] = eff_rate;
    end

    // Read mux; unmapped addresses read zero
    assign rd_mux =
        (haddr_i == APC_OFS_CAP)    ? APC_CAP_VALUE :
        (haddr_i == APC_OFS_CMD)    ? cmd_word      :
        (haddr_i == APC_OFS_STATUS) ? status_word   :
                                      32'h0000_0000;

    // Read data registered for the data phase
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (addr_ph && !hwrite_i) begin
            hrdata_o <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Rate and write protocol selection
    // ------------------------------------------------------------
    // Illegal rate codes are software's fault; 1x is the safe fallback
    assign eff_rate = apc_rate_decode(ctrl_q.rate_select);

    // Fast write only above 1x
    assign fast_sel = ctrl_q.fast_write_enable
                   && (eff_rate != APC_RATE_1X);

    // Data bus and sideband rate follow the decoded field, registered one cycle later
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            xfer_rate_o <= APC_RATE_1X;
        end else begin
            xfer_rate_o <= eff_rate;
        end
    end

    // Mode latched per write so a mid-write change cannot split it
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_fast_o <= 1'b0;
            wr_rate_o <= APC_RATE_1X;
        end else if (wr_req_i) begin
            wr_fast_o <= fast_sel;
            wr_rate_o <= fast_sel ? eff_rate : APC_RATE_1X;
        end
    end

    // ------------------------------------------------------------
    // Sideband strobe sync cycle
    // ------------------------------------------------------------
    // Edge of synced strobe
    assign sync_rise = sync_s && !sync_prev_q;

    // Sync pulses ignored while the port is disabled
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_prev_q <= 1'b0;
            sync_done_o <= 1'b0;
            sync_seen_q <= 1'b0;
        end else begin
            sync_prev_q <= sync_s;
            sync_done_o <= sync_rise && ctrl_q.port_enable;
            if (sync_rise && ctrl_q.port_enable) begin
                sync_seen_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Request acceptance
    // ------------------------------------------------------------
    // Sideband needs both enables; pipe needs the port enable only
    assign sb_accept = ctrl_q.port_enable
                    && ctrl_q.sideband_address_enable;

    // Held pipe waits its turn
    assign pipe_take = !pending_q && !pipe_req_n_s
                    && ctrl_q.port_enable;

    // Pipe wins a tie; sideband holds its request until taken
    assign sb_take   = !pending_q && sb_valid && !pipe_take;

    // Pairs bytes into requests
    apc_sideband u_sideband (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .byte_i   (sb_addr_s),
        .accept_i (sb_accept),
        .ready_i  (sb_take),
        .valid_o  (sb_valid),
        .cmd_o    (sb_cmd)
    );

    // ------------------------------------------------------------
    // Issued operation, held until the engine finishes it
    // ------------------------------------------------------------
    // Enable is not looked at once pending, so it always completes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pending_q <= 1'b0;
            op_q      <= '0;
        end else if (pending_q) begin
            if (op_done_i) begin
                pending_q <= 1'b0;
            end
        end else if (pipe_take) begin
            pending_q <= 1'b1;
            op_q      <= '{from_sideband: 1'b0, cmd: pipe_cmd_s};
        end else if (sb_take) begin
            pending_q <= 1'b1;
            op_q      <= '{from_sideband: 1'b1, cmd: sb_cmd};
        end
    end

    // Straight from registers
    assign op_valid_o = pending_q;
    assign op_o       = op_q;

endmodule : apc_top

// >>> test/apc_props.sv
// Checker for the port command block, bound to apc_top.
// Assumes one clock and a word-only AHB-Lite master.
`timescale 1ns/10ps
module apc_props
    import apc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_o,
    input  wire logic        op_valid_o,
    input  wire apc_op_type  op_o,
    input  wire logic        op_done_i,
    input  wire logic        sync_done_o,
    input  wire logic [2:0]  xfer_rate_o,
    input  wire logic        wr_req_i,
    input  wire logic        wr_fast_o,
    input  wire logic [2:0]  wr_rate_o
);
    // ----
    // Shadow of the command register
    // ----
    logic        wp_q;
    logic [31:0] cmd_q;
    logic        take_w;
    logic        fast_w;
    logic [2:0]  rate_w;
    logic [2:0]  wrr_w;
    assign take_w = hsel_i & hready_i & htrans_i[1];
    // Codes that are not one-hot act as 1x
    assign rate_w = (cmd_q[2:0] == APC_RATE_2X ||
                     cmd_q[2:0] == APC_RATE_4X) ? cmd_q[2:0] : APC_RATE_1X;
    assign fast_w = cmd_q[APC_FW_EN_BIT] & (rate_w != APC_RATE_1X);
    assign wrr_w  = fast_w ? rate_w : APC_RATE_1X;
    // Data phase of a word write to the command offset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_q  <= 1'b0;
            cmd_q <= APC_CMD_RESET;
        end else begin
            wp_q <= take_w & hwrite_i & (hsize_i == APC_HSIZE_WORD)
                    & (haddr_i == APC_OFS_CMD);
            if (wp_q)
                cmd_q <= hwdata_i & APC_CMD_WMASK;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_rate_out;
        $stable(cmd_q)[*3] |-> xfer_rate_o == rate_w;
    endproperty
    a_rate_out: assert property (p_rate_out)
        else $error("bus rate differs from command");
    property p_wr_fast;
        wr_req_i |=> wr_fast_o == $past(fast_w);
    endproperty
    a_wr_fast: assert property (p_wr_fast)
        else $error("write protocol wrong");
    property p_wr_rate;
        wr_req_i |=> wr_rate_o == $past(wrr_w);
    endproperty
    a_wr_rate: assert property (p_wr_rate)
        else $error("write rate wrong");
    property p_op_hold;
        op_valid_o && !op_done_i |=> op_valid_o && $stable(op_o);
    endproperty
    a_op_hold: assert property (p_op_hold)
        else $error("pending operation dropped");
    property p_op_done;
        op_valid_o && op_done_i |=> !op_valid_o;
    endproperty
    a_op_done: assert property (p_op_done)
        else $error("operation outlived its done");
    property p_pipe_en;
        $rose(op_valid_o) && !op_o.from_sideband
            |-> $past(cmd_q[8]) || $past(cmd_q[8], 2);
    endproperty
    a_pipe_en: assert property (p_pipe_en)
        else $error("pipe request taken while off");
    property p_sync_en;
        sync_done_o |-> $past(cmd_q[8]) || $past(cmd_q[8], 2);
    endproperty
    a_sync_en: assert property (p_sync_en)
        else $error("sync taken while off");
    property p_rd_cmd;
        take_w && !hwrite_i && haddr_i == APC_OFS_CMD |=> hrdata_o == cmd_q;
    endproperty
    a_rd_cmd: assert property (p_rd_cmd)
        else $error("command readback wrong");
    property p_rd_cap;
        take_w && !hwrite_i && haddr_i == APC_OFS_CAP
            |=> hrdata_o == APC_CAP_VALUE;
    endproperty
    a_rd_cap: assert property (p_rd_cap)
        else $error("capability readback wrong");

    c_sb_op: cover property ($rose(op_valid_o) && op_o.from_sideband);
    c_fast:  cover property (wr_req_i && fast_w);
    c_sync:  cover property (sync_done_o);
endmodule : apc_props

// >>> test/apc_agp_model.sv
// Graphics master model driving the port pins.
// Assumes the bench calls its tasks; pins change after clk_i edges.
`timescale 1ns/10ps
module apc_agp_model
    import apc_pkg::*;
(
    input  wire logic        clk_i,
    output logic             pipe_req_n_o,
    output logic [15:0]      pipe_cmd_o,
    output logic [7:0]       sb_addr_o,
    output logic             sb_sync_o
);
    // Idle pins at time zero
    initial begin
        pipe_req_n_o = 1'b1;
        pipe_cmd_o   = 16'h0000;
        sb_addr_o    = APC_SB_IDLE;
        sb_sync_o    = 1'b0;
    end
    // Request held for hold cycles; slow masters use a long hold
    task automatic pipe_req(input logic [15:0] cmd, input int hold);
        @(posedge clk_i);
        pipe_req_n_o <= 1'b0;
        pipe_cmd_o   <= cmd;
        repeat (hold) @(posedge clk_i);
        pipe_req_n_o <= 1'b1;
        pipe_cmd_o   <= ~cmd; // Released word must not look valid
    endtask : pipe_req
    // Two bytes, high first, then back to idle
    task automatic sb_send(input logic [15:0] cmd);
        @(posedge clk_i);
        sb_addr_o <= cmd[15:8];
        @(posedge clk_i);
        sb_addr_o <= cmd[7:0];
        @(posedge clk_i);
        sb_addr_o <= APC_SB_IDLE;
    endtask : sb_send
    task automatic sync_pulse();
        @(posedge clk_i);
        sb_sync_o <= 1'b1;
        @(posedge clk_i);
        sb_sync_o <= 1'b0;
    endtask : sync_pulse
endmodule : apc_agp_model

// >>> test/agp_command_control_tb.sv
// Self-checking bench for apc_top with a graphics master model.
// Assumes 100 ns clock; the engine side is played by the bench.
`timescale 1ns/10ps
module agp_command_control_tb
    import apc_pkg::*;
;
    logic clk_i, arst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [1:0]  htrans_i;
    logic [2:0]  hsize_i, xfer_rate_o, wr_rate_o;
    logic pipe_req_n_i, sb_sync_i, op_valid_o, op_done_i, sync_done_o;
    logic [15:0] pipe_cmd_i;
    logic [7:0]  sb_addr_i;
    apc_op_type  op_o;
    logic wr_req_i, wr_fast_o, s;
    int bad_count, compares;

    apc_top apc_top_i (.clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o),
        .hrdata_o, .hreadyout_o, .hresp_o, .pipe_req_n_i, .pipe_cmd_i,
        .sb_addr_i, .sb_sync_i, .op_valid_o, .op_o, .op_done_i,
        .sync_done_o, .xfer_rate_o, .wr_req_i, .wr_fast_o, .wr_rate_o);
    apc_agp_model apc_agp_model_i (.clk_i, .pipe_req_n_o(pipe_req_n_i),
        .pipe_cmd_o(pipe_cmd_i), .sb_addr_o(sb_addr_i),
        .sb_sync_o(sb_sync_i));

    always #50 clk_i = ~clk_i;

    // ----
    // Shared tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i <= a;
        hwrite_i <= w;
        hsize_i <= APC_HSIZE_WORD;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rdc(input string nm, input logic [31:0] a,
                       input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk(nm, x, exp);
    endtask : rdc
    task automatic watch(input int n);
        s = 1'b0;
        repeat (n) begin
            @(posedge clk_i);
            s = s | op_valid_o | sync_done_o;
        end
    endtask : watch
    task automatic wait_op(input logic [16:0] exp);
        int n;
        n = 0;
        while (op_valid_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        chk("operation", {15'h0, op_o}, {15'h0, exp});
    endtask : wait_op
    task automatic done_op();
        @(posedge clk_i);
        op_done_i <= 1'b1;
        @(posedge clk_i);
        op_done_i <= 1'b0;
        #1 chk("op retired", {31'h0, op_valid_o}, 32'h0000_0000);
    endtask : done_op
    task automatic wreq(input logic f, input logic [2:0] r);
        @(posedge clk_i);
        wr_req_i <= 1'b1;
        @(posedge clk_i);
        wr_req_i <= 1'b0;
        #1 chk("fast", {31'h0, wr_fast_o}, {31'h0, f});
        chk("write rate", {29'h0, wr_rate_o}, {29'h0, r});
    endtask : wreq

    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        rdc("cap", APC_OFS_CAP, APC_CAP_VALUE);
        rdc("cmd reset", APC_OFS_CMD, 32'h0000_0000);
        wr(APC_OFS_CMD, 32'hffff_ffff);
        rdc("cmd mask", APC_OFS_CMD, APC_CMD_WMASK);
        rdc("unmapped", 32'h0000_00b0, 32'h0000_0000);
    endtask : t_regs
    task automatic t_rates();
        logic [2:0] r;
        for (int i = 0; i < 3; i++) begin
            r = 3'h1 << i;
            wr(APC_OFS_CMD, {27'h0, 2'b10, r});
            repeat (3) @(posedge clk_i);
            chk("bus rate", {29'h0, xfer_rate_o}, {29'h0, r});
            wreq(i != 0, r);
        end
        wr(APC_OFS_CMD, 32'h0000_0004);
        wreq(1'b0, APC_RATE_1X);
    endtask : t_rates
    task automatic t_off();
        wr(APC_OFS_CMD, 32'h0000_0001);
        fork
            apc_agp_model_i.pipe_req(16'h1111, 6);
            apc_agp_model_i.sync_pulse();
            watch(10);
        join
        chk("port off", {31'h0, s}, 32'h0000_0000);
        wr(APC_OFS_CMD, 32'h0000_0101);
        apc_agp_model_i.sb_send(16'h5aa5);
        watch(10);
        chk("sideband off", {31'h0, s}, 32'h0000_0000);
        apc_agp_model_i.sync_pulse();
        watch(8);
        chk("sync on", {31'h0, s}, 32'h0000_0001);
    endtask : t_off
    task automatic t_pipe();
        fork
            apc_agp_model_i.pipe_req(16'h1234, 3);
        join_none
        wait_op({1'b0, 16'h1234});
        wr(APC_OFS_CMD, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        chk("op kept", {31'h0, op_valid_o}, 32'h0000_0001);
        done_op();
    endtask : t_pipe
    task automatic t_sb();
        wr(APC_OFS_CMD, 32'h0000_0301);
        apc_agp_model_i.sb_send(16'ha55a);
        wait_op({1'b1, 16'ha55a});
        done_op();
        // Enable drops between the two bytes
        fork
            apc_agp_model_i.sb_send(16'h3cc3);
            begin
                @(posedge clk_i);
                wr(APC_OFS_CMD, 32'h0000_0201);
            end
        join
        wait_op({1'b1, 16'h3cc3});
        done_op();
    endtask : t_sb

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // Reset, then the scenarios in turn
    initial begin
        {clk_i, arst_n_i, hsel_i, hwrite_i, htrans_i} = '0;
        {haddr_i, hwdata_i, hsize_i, op_done_i, wr_req_i} = '0;
        bad_count = 0;
        compares = 0;
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_rates();
        t_off();
        t_pipe();
        t_sb();
        test_done();
    end
    // Whole run needs well under 1000 cycles
    initial begin
        #(100 * 4000);
        bad_count++;
        test_done();
    end
endmodule : agp_command_control_tb

bind apc_top apc_props apc_props_i (.clk_i, .arst_n_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o,
    .op_valid_o, .op_o, .op_done_i, .sync_done_o, .xfer_rate_o, .wr_req_i,
    .wr_fast_o, .wr_rate_o);
